//--- hw/lamp_strike_run_fault_sequencer.sv
// Purpose: Power-on delay, strike, run and fault sequencer for a lamp inverter
// Assumes: clk_sys is the ramp clock, twice the lamp current frequency; rstn is supply power-up
// Notes: Lamp pulses arrive as a comparator pin and are synchronised here
//   Enable, lamp pulse and over-voltage pins each cost two cycles of latency
//   One sweep of SWEEP_RAMPS ramps is the power-on delay; fifteen more bound strike
`timescale 1ns/100ps
`default_nettype none
`include "lamp_seq_regs.svh"
module lamp_strike_run_fault_sequencer #(
	parameter int SWEEP_RAMPS = `POWER_ON_DELAY_RAMPS,
	parameter int RUN_WINDOW = `RUN_WINDOW_RAMPS,
	parameter int DAC_W = 12,
	parameter logic [11:0] RUN_CODE = 12'h199
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic enable,
	input wire logic lamp_current_sense,
	input wire logic overvoltage_sense,
	input wire logic driveReqA,
	input wire logic driveReqB,
	output logic drive_out_a,
	output logic drive_out_b,
	output logic fault_indicator_pin,
	output logic dacSelect,
	output logic [DAC_W-1:0] dacCode,
	output logic [1:0] modeOut
);
	lamp_seq_pkg::mode_e mode_reg;
	lamp_seq_pkg::mode_e mode_next;
	// Synchronised pin levels and their rising edges
	logic enSync;
	logic pulseSync;
	logic ovSync;
	logic enRise;
	logic pulseRise;
	// Sequencing counters and latches
	logic [15:0] rampCnt_reg;
	logic [4:0] sweepCnt_reg;
	logic [3:0] pulseCnt_reg;
	logic [15:0] winCnt_reg;
	logic frozen_reg;
	logic struck_reg;
	// Decoded events for the current cycle
	logic sweepEnd;
	logic lastSweepEnd;
	logic winEnd;
	logic ignited;
	logic windowLit;
	logic freezeNow;
	logic dacAtCeiling;

	// Pulse threshold met, counting a rise that lands in this very cycle
	// Shared by the strike ignition test and the run window test
	// Counting the live rise saves one cycle of drive at the threshold
	function automatic logic pulses_met(input logic [3:0] count, input logic rise);
		pulses_met = (count >= `IGNITE_PULSES) || ((count == 4'(`IGNITE_PULSES - 1)) && rise);
	endfunction

	// Modes in which the output drivers may follow their requests
	// Delay and fault both keep the drivers inhibited
	// Used for both drivers so their gating can never drift apart
	function automatic logic drive_allowed(input lamp_seq_pkg::mode_e mode);
		drive_allowed = (mode == lamp_seq_pkg::MODE_STRIKE) || (mode == lamp_seq_pkg::MODE_RUN);
	endfunction

	// Enable pin capture
	pin_sync uEnSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.pinIn(enable),
		.pinOut(enSync)
	);

	// Lamp current comparator capture
	pin_sync uPulseSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.pinIn(lamp_current_sense),
		.pinOut(pulseSync)
	);

	// Over-voltage comparator capture
	pin_sync uOvSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.pinIn(overvoltage_sense),
		.pinOut(ovSync)
	);

	// Enable rise restarts the sequence
	// Its history flop resets low like the idle pin, so reset gives no false edge
	rise_detect uEnRise (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.levelIn(enSync),
		.risePulse(enRise)
	);

	// One pulse per lamp current cycle
	// The comparator idles low, so the first rise after reset is a real one
	rise_detect uPulseRise (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.levelIn(pulseSync),
		.risePulse(pulseRise)
	);

	// Sweep boundary, last strike sweep and run window boundary
	assign sweepEnd = (rampCnt_reg == 16'(SWEEP_RAMPS - 1));
	assign lastSweepEnd = sweepEnd && (sweepCnt_reg == `STRIKE_SWEEPS);
	assign winEnd = (winCnt_reg == 16'(RUN_WINDOW - 1));

	// Eight pulses ignite in strike and keep a run window alive
	assign ignited = pulses_met(pulseCnt_reg, pulseRise);
	assign windowLit = pulses_met(pulseCnt_reg, pulseRise);

	// Sweep freezes on the synchronised trip at once, then by the latch
	assign freezeNow = frozen_reg || ovSync;
	assign dacAtCeiling = (dacCode >= DAC_W'(RUN_CODE * `DAC_MULT));

	// Mode transitions
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			lamp_seq_pkg::MODE_DELAY: begin
				if (enSync && sweepEnd && sweepCnt_reg == 5'h00) begin
					mode_next = struck_reg ? lamp_seq_pkg::MODE_FAULT : lamp_seq_pkg::MODE_STRIKE;
				end
			end
			lamp_seq_pkg::MODE_STRIKE: begin
				// Ignition wins over a timeout on the same edge
				if (ignited) begin
					mode_next = lamp_seq_pkg::MODE_RUN;
				end else if (lastSweepEnd) begin
					mode_next = lamp_seq_pkg::MODE_FAULT;
				end
			end
			lamp_seq_pkg::MODE_RUN: begin
				// A window that ends short of eight pulses means the lamp went out
				if (winEnd && !windowLit) begin
					mode_next = lamp_seq_pkg::MODE_FAULT;
				end
			end
			lamp_seq_pkg::MODE_FAULT: begin
				mode_next = lamp_seq_pkg::MODE_FAULT;
			end
			default: begin
				mode_next = lamp_seq_pkg::MODE_FAULT;
			end
		endcase
		// Enable low overrides every mode and parks the sequencer in delay
		if (!enSync) begin
			mode_next = lamp_seq_pkg::MODE_DELAY;
		end
	end

	// Mode register; enable rise restarts the delay
	// The restart wins over mode_next so a fault cannot outlive an enable cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= lamp_seq_pkg::MODE_DELAY;
		end else if (ce) begin
			if (enRise) begin
				mode_reg <= lamp_seq_pkg::MODE_DELAY;
			end else begin
				mode_reg <= mode_next;
			end
		end
	end

	// Strike-once latch, cleared by enable low or power cycle
	// Enable low clears it on the same edge that returns the mode to delay, so a later pass through delay still reaches strike
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			struck_reg <= 1'b0;
		end else if (ce) begin
			if (!enSync) begin
				struck_reg <= 1'b0;
			end else if (mode_reg == lamp_seq_pkg::MODE_STRIKE) begin
				struck_reg <= 1'b1;
			end
		end
	end

	// Ramp counter: ramps within one sweep, cleared outside delay and strike
	// Run and fault park it so a later enable always starts a whole delay sweep
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rampCnt_reg <= 16'h0000;
		end else if (ce) begin
			if (enRise || !enSync || mode_reg == lamp_seq_pkg::MODE_RUN || mode_reg == lamp_seq_pkg::MODE_FAULT) begin
				rampCnt_reg <= 16'h0000;
			end else if (sweepEnd) begin
				rampCnt_reg <= 16'h0000;
			end else begin
				rampCnt_reg <= rampCnt_reg + 16'h0001;
			end
		end
	end

	// Sweep counter: sweep 0 is the power-on delay, sweeps 1 to 15 are strike
	// Sixteen sweeps from delay start bound the whole strike attempt
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sweepCnt_reg <= 5'h00;
		end else if (ce) begin
			if (enRise || !enSync || mode_reg == lamp_seq_pkg::MODE_RUN || mode_reg == lamp_seq_pkg::MODE_FAULT) begin
				sweepCnt_reg <= 5'h00;
			end else if (sweepEnd) begin
				sweepCnt_reg <= sweepCnt_reg + 5'h01;
			end
		end
	end

	// Lamp pulse counter: strike accumulates, run restarts it each window
	// A rise on the clearing edge is dropped; the window keeps ample margin
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pulseCnt_reg <= 4'h0;
		end else if (ce) begin
			if (mode_reg == lamp_seq_pkg::MODE_DELAY || mode_reg == lamp_seq_pkg::MODE_FAULT) begin
				pulseCnt_reg <= 4'h0;
			end else if (mode_reg == lamp_seq_pkg::MODE_STRIKE && mode_next == lamp_seq_pkg::MODE_RUN) begin
				pulseCnt_reg <= 4'h0;
			end else if (mode_reg == lamp_seq_pkg::MODE_RUN && winEnd) begin
				pulseCnt_reg <= 4'h0;
			end else if (pulseRise && pulseCnt_reg != 4'hF) begin
				pulseCnt_reg <= pulseCnt_reg + 4'h1;
			end
		end
	end

	// Run window counter: counts ramps only while running
	// Held at zero elsewhere so the first window starts with run itself
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winCnt_reg <= 16'h0000;
		end else if (ce) begin
			if (mode_reg != lamp_seq_pkg::MODE_RUN || winEnd) begin
				winCnt_reg <= 16'h0000;
			end else begin
				winCnt_reg <= winCnt_reg + 16'h0001;
			end
		end
	end

	// Over-voltage freeze latch
	// Held until strike ends so the strike voltage stays at its safe level
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frozen_reg <= 1'b0;
		end else if (ce) begin
			if (mode_reg != lamp_seq_pkg::MODE_STRIKE) begin
				frozen_reg <= 1'b0;
			end else if (ovSync) begin
				frozen_reg <= 1'b1;
			end
		end
	end

	// DAC sawtooth from run code to five times it within each sweep
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dacCode <= DAC_W'(RUN_CODE);
		end else if (ce) begin
			if (mode_reg != lamp_seq_pkg::MODE_STRIKE) begin
				dacCode <= DAC_W'(RUN_CODE);
			end else if (freezeNow) begin
				dacCode <= dacCode;
			end else if (sweepEnd) begin
				dacCode <= DAC_W'(RUN_CODE);
			// At the ceiling the code waits for the sweep end
			end else if (!dacAtCeiling) begin
				dacCode <= dacCode + DAC_W'(1);
			end
		end
	end

	// Frequency source select: DAC only in strike
	// Combinational so the source swaps on the same edge as the mode
	assign dacSelect = (mode_reg == lamp_seq_pkg::MODE_STRIKE);

	// Driver A follows its request only while strike or run is next
	// Gating on mode_next drops it on the edge the mode leaves; an enable restart blanks it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			drive_out_a <= 1'b0;
		end else if (ce) begin
			drive_out_a <= driveReqA && drive_allowed(mode_next) && !enRise;
		end
	end

	// Driver B, same gating as driver A
	// Both outputs share one decode so they can never disagree on the mode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			drive_out_b <= 1'b0;
		end else if (ce) begin
			drive_out_b <= driveReqB && drive_allowed(mode_next) && !enRise;
		end
	end

	// Fault indicator rises with the edge that enters fault and stands there
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fault_indicator_pin <= 1'b0;
		end else if (ce) begin
			fault_indicator_pin <= (mode_next == lamp_seq_pkg::MODE_FAULT) && !enRise;
		end
	end

	// Present mode for monitoring, Gray coded
	assign modeOut = mode_reg;
endmodule
`default_nettype wire

//--- include/lamp_seq_regs.svh
// Purpose: Timing counts and field constants for the lamp mode sequencer
// Assumes: Counts are in ramp clock periods
// Notes: Definitions only
`ifndef LAMP_SEQ_REGS_SVH
`define LAMP_SEQ_REGS_SVH
`define SWEEP_LEN 16'h4000
`define SWEEP_COUNT 5'h10
`define STRIKE_SWEEPS 5'h0F
`define POWER_ON_DELAY_RAMPS 16'h4000
`define IGNITE_PULSES 4'h8
`define RUN_WINDOW_RAMPS 16'h2000
`define DAC_MULT 4'h5
`endif

//--- include/lamp_seq_pkg.sv
// Purpose: Types shared by the lamp mode sequencer
// Assumes: Nothing
// Notes: Gray coded modes along power-on, strike, run, fault
package lamp_seq_pkg;
	typedef enum logic [1:0] {
		MODE_DELAY = 2'h0,
		MODE_STRIKE = 2'h1,
		MODE_RUN = 2'h3,
		MODE_FAULT = 2'h2
	} mode_e;
endpackage

//--- hw/pin_sync.sv
// Purpose: Two flop synchroniser for one pin
// Assumes: Single clock domain
// Notes: First flop only feeds the second
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic pinIn,
	output logic pinOut
);
	logic stage1Reg;
	// Two stage capture
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1Reg <= 1'b0;
			pinOut <= 1'b0;
		end else if (ce) begin
			stage1Reg <= pinIn;
			pinOut <= stage1Reg;
		end
	end
endmodule
`default_nettype wire

//--- hw/rise_detect.sv
// Purpose: Rising edge pulse from a synchronised level
// Assumes: Input already synchronised
// Notes: One cycle pulse
`timescale 1ns/100ps
`default_nettype none
module rise_detect (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic levelIn,
	output logic risePulse
);
	logic levelDlyReg;
	// Previous value
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			levelDlyReg <= 1'b0;
		end else if (ce) begin
			levelDlyReg <= levelIn;
		end
	end
	// Edge output
	assign risePulse = ce & levelIn & ~levelDlyReg;
endmodule
`default_nettype wire

//--- test/lamp_seq_asserts.sv
// Purpose: Mode sequencer port checks
// Assumes: Top module ports only
// Notes: Bound at the foot
`timescale 1ns/100ps
`default_nettype none
module lamp_seq_asserts #(
	parameter int DAC_W = 12,
	parameter logic [11:0] RUN_CODE = 12'h199
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic enable,
	input wire logic overvoltage_sense,
	input wire logic driveReqA,
	input wire logic drive_out_a,
	input wire logic drive_out_b,
	input wire logic fault_indicator_pin,
	input wire logic dacSelect,
	input wire logic [DAC_W-1:0] dacCode,
	input wire logic [1:0] modeOut
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	a_delay_inhibit: assert property (modeOut == lamp_seq_pkg::MODE_DELAY |-> !drive_out_a && !drive_out_b)
		else $error("drive during delay");
	a_fault_off: assert property (modeOut == lamp_seq_pkg::MODE_FAULT |-> !drive_out_a && !drive_out_b)
		else $error("drive during fault");
	a_fault_flag: assert property ((modeOut == lamp_seq_pkg::MODE_FAULT)[*2] |-> fault_indicator_pin)
		else $error("fault flag low");
	a_dac_select: assert property (dacSelect == (modeOut == lamp_seq_pkg::MODE_STRIKE))
		else $error("ramp source wrong");
	a_run_code: assert property ((modeOut == lamp_seq_pkg::MODE_RUN)[*2] |-> dacCode == RUN_CODE)
		else $error("run code wrong");
	a_strike_entry: assert property ($changed(modeOut) && modeOut == lamp_seq_pkg::MODE_STRIKE |->
		$past(modeOut) == lamp_seq_pkg::MODE_DELAY) else $error("strike not from delay");
	a_run_entry: assert property ($changed(modeOut) && modeOut == lamp_seq_pkg::MODE_RUN |->
		$past(modeOut) == lamp_seq_pkg::MODE_STRIKE) else $error("run not from strike");
	a_dac_ceiling: assert property (modeOut == lamp_seq_pkg::MODE_STRIKE |-> dacCode <= RUN_CODE * 5)
		else $error("sweep above ceiling");
	a_ov_freeze: assert property ((modeOut == lamp_seq_pkg::MODE_STRIKE && overvoltage_sense)[*4] |=>
		modeOut != lamp_seq_pkg::MODE_STRIKE || $stable(dacCode)) else $error("sweep not frozen");
	a_run_drive: assert property ((modeOut == lamp_seq_pkg::MODE_RUN)[*2] |-> drive_out_a == $past(driveReqA))
		else $error("run drive not passed");
	a_fault_sticky: assert property ((modeOut == lamp_seq_pkg::MODE_FAULT && enable)[*6] |=>
		modeOut == lamp_seq_pkg::MODE_FAULT) else $error("fault left");
	// Main modes reached
	c_strike: cover property (modeOut == lamp_seq_pkg::MODE_STRIKE);
	c_run: cover property (modeOut == lamp_seq_pkg::MODE_RUN);
	c_fault: cover property (modeOut == lamp_seq_pkg::MODE_FAULT);
endmodule
bind lamp_strike_run_fault_sequencer lamp_seq_asserts #(.DAC_W(DAC_W), .RUN_CODE(RUN_CODE)) chk_u (
	.clk_sys, .rstn, .enable, .overvoltage_sense, .driveReqA, .drive_out_a, .drive_out_b,
	.fault_indicator_pin, .dacSelect, .dacCode, .modeOut);
`default_nettype wire

//--- test/lamp_load_model.sv
// Purpose: Drive stage and lamp sense model
// Assumes: Lamp current at half the ramp clock
// Notes: Sense idles low without current
`timescale 1ns/100ps
`default_nettype none
module lamp_load_model (
	input wire logic clk_sys,
	input wire logic drive_out_a,
	input wire logic drive_out_b,
	input wire logic lampLit,
	input wire logic ovTrip,
	output logic lamp_current_sense = 1'b0,
	output logic overvoltage_sense = 1'b0
);
	// Comparator toggles while a lit lamp is driven
	always @(posedge clk_sys) begin
		lamp_current_sense <= #2 lampLit && (drive_out_a || drive_out_b) && !lamp_current_sense;
	end
	// Divider trip follows the request
	always @(posedge clk_sys) begin
		overvoltage_sense <= #2 ovTrip;
	end
endmodule
`default_nettype wire

//--- test/test_lamp_strike_run_fault_sequencer.sv
// Purpose: Mode sequence bench
// Assumes: Short sweep and window counts
// Notes: Inputs move 2 ns after the edge
`timescale 1ns/100ps
`default_nettype none
module test_lamp_strike_run_fault_sequencer;
	localparam logic [11:0] CODE = 12'h199;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic enable = 1'b0;
	logic driveReqA = 1'b0;
	logic lampLit = 1'b0;
	logic ovTrip = 1'b0;
	logic lamp_current_sense, overvoltage_sense, drive_out_a, drive_out_b, fault_indicator_pin, dacSelect;
	logic [11:0] dacCode, held;
	logic [1:0] modeOut;
	int n_errors = 0;
	int num_checks = 0;
	int n;
	// Clock and alternating drive phases
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) driveReqA <= #2 ~driveReqA;
	lamp_strike_run_fault_sequencer #(.SWEEP_RAMPS(16), .RUN_WINDOW(32), .RUN_CODE(CODE)) dut_u (
		.clk_sys, .rstn, .ce(1'b1), .enable, .lamp_current_sense, .overvoltage_sense, .driveReqA,
		.driveReqB(~driveReqA), .drive_out_a, .drive_out_b, .fault_indicator_pin, .dacSelect, .dacCode, .modeOut);
	lamp_load_model load_u (.clk_sys, .drive_out_a, .drive_out_b, .lampLit, .ovTrip, .lamp_current_sense,
		.overvoltage_sense);
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim);
		n = 0;
		while (modeOut !== m && n < lim) begin
			cyc(1);
			n++;
		end
		check(modeOut, m);
	endtask
	// Delay, strike with a lit lamp, then run
	task automatic test_ignite();
		enable = 1'b1;
		wait_mode(lamp_seq_pkg::MODE_STRIKE, 60);
		check({11'h000, n >= 17 && n <= 22}, 12'h001);
		check(dacSelect, 1'b1);
		lampLit = 1'b1;
		wait_mode(lamp_seq_pkg::MODE_RUN, 60);
		check({11'h000, n >= 15}, 12'h001);
		cyc(2);
		check({dacSelect, dacCode}, {1'b0, CODE});
		check({11'h000, drive_out_a ^ drive_out_b}, 12'h001);
		cyc(100);
		check(modeOut, lamp_seq_pkg::MODE_RUN);
	endtask
	// Lamp goes out in run, fault holds while enabled
	task automatic test_extinguish();
		lampLit = 1'b0;
		wait_mode(lamp_seq_pkg::MODE_FAULT, 80);
		cyc(2);
		check({fault_indicator_pin, drive_out_a, drive_out_b}, 12'h004);
		cyc(100);
		check(modeOut, lamp_seq_pkg::MODE_FAULT);
	endtask
	// Enable cycle, frozen sweep, strike timeout
	task automatic test_timeout();
		enable = 1'b0;
		cyc(6);
		check(modeOut, lamp_seq_pkg::MODE_DELAY);
		enable = 1'b1;
		wait_mode(lamp_seq_pkg::MODE_STRIKE, 60);
		cyc(20);
		ovTrip = 1'b1;
		cyc(6);
		held = dacCode;
		cyc(10);
		check(dacCode, held);
		wait_mode(lamp_seq_pkg::MODE_FAULT, 300);
		check({11'h000, n + 36 >= 236 && n + 36 <= 244}, 12'h001);
		ovTrip = 1'b0;
		cyc(2);
		check({fault_indicator_pin, drive_out_a, drive_out_b}, 12'h004);
	endtask
	// Supply cycle restarts the delay
	task automatic test_power();
		rstn = 1'b0;
		cyc(2);
		check({modeOut, dacCode}, {lamp_seq_pkg::MODE_DELAY, CODE});
		rstn = 1'b1;
		cyc(5);
		check({modeOut, fault_indicator_pin}, {lamp_seq_pkg::MODE_DELAY, 1'b0});
		wait_mode(lamp_seq_pkg::MODE_STRIKE, 60);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(5);
		rstn = 1'b1;
		test_ignite();
		test_extinguish();
		test_timeout();
		test_power();
		tally_and_finish();
	end
	// Watchdog well beyond the expected 600 or so cycles
	initial begin
		#(25 * 4000);
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
